// File: verilog/dtp_pkg.sv
// constants, register map and state types of the dual timer pair
// Notes on behaviour
// R1 - prescale divides 1, 8, 64 or 256
// R2 - combined mode: low half clock and prescaler only
// R3 - count register write clears prescaler
// R4 - clearing timer_on clears prescaler
// R5 - any reset clears prescaler
// R6 - disabled low timer prescaler cannot be cleared
// R7 - control write leaves count unchanged
// R8 - no counting during CPU sleep
// R9 - 32-bit match or gate fall sets flag
// R10 - software clears the interrupt flag
// R11 - holding register used only when combined
// R12 - control fields as listed, reset zero
// R13 - second pair: no trigger, no capture base
// R14 - combined: high control ignored, high flag used
// R15 - low timer is least significant word
// R16 - count to period, wrap to zero
// R17 - low read latches high; holding then low write
// R18 - gated mode counts while gate high
// R19 - 32-bit match pulses converter trigger
// R20 - event pulse one cycle, flag stays set
package dtp_pkg;

   // ==========================================================
   // register word indices; byte address is four times index
   localparam logic [11:0] IDX_LO_CNT      = 12'h106;
   localparam logic [11:0] IDX_HOLD        = 12'h108;
   localparam logic [11:0] IDX_HI_CNT      = 12'h10A;
   localparam logic [11:0] IDX_LO_PER      = 12'h10C;
   localparam logic [11:0] IDX_HI_PER      = 12'h10E;
   localparam logic [11:0] IDX_LO_CON      = 12'h110;
   localparam logic [11:0] IDX_HI_CON      = 12'h112;
   localparam logic [11:0] IDX_PAIR_STRIDE = 12'h00E;
   localparam logic [11:0] IDX_IRQ_FLAG    = 12'h130;
   localparam logic [11:0] IDX_IRQ_EN      = 12'h132;

   // ==========================================================
   // control field positions and masks
   localparam int          B_TON        = 15;
   localparam int          B_STOP_IN_IDLE      = 13;
   localparam int          B_GATE_ACCUMULATE_ENABLE      = 6;
   localparam int          B_PS_HI      = 5;
   localparam int          B_PS_LO      = 4;
   localparam int          B_T32        = 3;
   localparam int          B_TCS        = 1;
   localparam logic [15:0] CON_LO_MASK  = 16'hA07A;
   localparam logic [15:0] CON_HI_MASK  = 16'hA072;
   localparam logic [15:0] CON_RST      = 16'h0000;
   localparam logic [15:0] PER_RST      = 16'hFFFF;
   localparam logic [15:0] CNT_RST      = 16'h0000;
   localparam int          IRQ_FLAG_LSB = 6;

   // ==========================================================
   // prescaler terminal counts
   localparam logic [1:0] PS_SEL_1    = 2'h0;
   localparam logic [1:0] PS_SEL_8    = 2'h1;
   localparam logic [1:0] PS_SEL_64   = 2'h2;
   localparam logic [7:0] PS_TERM_1   = 8'h00;
   localparam logic [7:0] PS_TERM_8   = 8'h07;
   localparam logic [7:0] PS_TERM_64  = 8'h3F;
   localparam logic [7:0] PS_TERM_256 = 8'hFF;
   localparam logic [7:0] PS_RST      = 8'h00;

   // ==========================================================
   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // state types
   typedef struct packed {
      logic [15:0] lo;
      logic [15:0] hi;
      logic [15:0] hold;
      logic [15:0] prl;
      logic [15:0] prh;
      logic [15:0] conl;
      logic [15:0] conh;
      logic [7:0]  psl;
      logic [7:0]  psh;
      logic [2:0]  sync_l;
      logic [2:0]  sync_h;
      logic        stab_l;
      logic        stab_h;
   } dtp_pair_t;

   typedef struct packed {
      dtp_pair_t [1:0] p;
      logic [3:0]      flags;
      logic [3:0]      ens;
      logic [3:0]      irq;
      logic            adc;
      logic            aw_have;
      logic            w_have;
      logic [11:0]     awaddr;
      logic [15:0]     wdata;
      logic [1:0]      wstrb;
      logic            awready;
      logic            wready;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            arready;
      logic            rvalid;
      logic [31:0]     rdata;
      logic [1:0]      rresp;
   } dtp_state_t;

endpackage

// File: verilog/dtp_timer_pair.sv
// two chainable 16-bit timer pairs behind an AXI4-Lite slave
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module dtp_timer_pair (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                resetn,
   // register bus
   input  wire logic [11:0]         s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output var  logic                s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output var  logic                s_axi_wready,
   output var  logic [1:0]          s_axi_bresp,
   output var  logic                s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [11:0]         s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output var  logic                s_axi_arready,
   output var  logic [31:0]         s_axi_rdata,
   output var  logic [1:0]          s_axi_rresp,
   output var  logic                s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // cpu power state
   input  wire logic                cpu_sleep,
   input  wire logic                cpu_idle,
   // clock or gate pins, index pair*2 + half
   input  wire logic [3:0]          ck_pin,
   // events and count to capture logic
   output var  logic [3:0]          irq_req,
   output var  logic                adc_trigger,
   output var  logic [15:0]         cap_count_lo,
   output var  logic [15:0]         cap_count_hi
);
   import dtp_pkg::*;

   dtp_state_t q;
   dtp_state_t d;

   // ==========================================================
   // helpers
   function automatic logic [11:0] reg_addr(input logic [11:0] idx, input logic pair_b);
      logic [11:0] full;
      full = pair_b ? 12'(idx + IDX_PAIR_STRIDE) : idx;
      return {full[9:0], 2'h0};
   endfunction
   function automatic logic [7:0] ps_term(input logic [1:0] sel);
      case (sel)
         PS_SEL_1: ps_term = PS_TERM_1;
         PS_SEL_8: ps_term = PS_TERM_8;
         PS_SEL_64: ps_term = PS_TERM_64;
         default: ps_term = PS_TERM_256;
      endcase
   endfunction
   // returns {fire, next prescaler count}
   function automatic logic [8:0] ps_step(input logic [7:0] ps, input logic [1:0] sel,
                                          input logic adv);
      if (!adv) begin
         return {1'b0, ps};
      end
      if (ps >= ps_term(sel)) begin
         return {1'b1, PS_RST}; // R1
      end
      return {1'b0, 8'(ps + 8'h01)};
   endfunction
   function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] strb);
      logic [15:0] r;
      r = old;
      if (strb[0]) begin
         r[7:0] = nw[7:0];
      end
      if (strb[1]) begin
         r[15:8] = nw[15:8];
      end
      return r;
   endfunction
   function automatic logic runs(input logic [15:0] con);
      return con[B_TON] & ~cpu_sleep & ~(cpu_idle & con[B_STOP_IN_IDLE]); // R8
   endfunction
   function automatic logic gated(input logic [15:0] con);
      return con[B_TON] & con[B_GATE_ACCUMULATE_ENABLE] & ~con[B_TCS];
   endfunction
   function automatic logic timer_adv(input logic [15:0] con, input logic lvl, input logic rise);
      if (!runs(con)) begin
         return 1'b0;
      end
      if (!con[B_TCS]) begin
         return con[B_GATE_ACCUMULATE_ENABLE] ? lvl : 1'b1; // R18
      end
      return rise;
   endfunction

   // ==========================================================
   // next state
   always_comb begin
      dtp_pair_t   pp;
      logic [15:0] ch;
      logic        comb;
      logic        sl;
      logic        sh;
      logic        rl;
      logic        rh;
      logic        fall_l;
      logic        fall_h;
      logic [8:0]  st;
      logic [3:0]  ev;
      logic [31:0] cnt32;
      logic        wr_go;
      logic        hit;
      logic [11:0] wa;
      logic [11:0] ra;
      logic [15:0] w16;
      logic [15:0] rd;
      pp = '0;
      ch = '0;
      comb = 1'b0;
      sl = 1'b0;
      sh = 1'b0;
      rl = 1'b0;
      rh = 1'b0;
      fall_l = 1'b0;
      fall_h = 1'b0;
      st = '0;
      ev = '0;
      cnt32 = '0;
      hit = 1'b0;
      w16 = '0;
      rd = '0;
      wa = q.awaddr;
      ra = s_axi_araddr;
      wr_go = q.aw_have & q.w_have & ~q.bvalid;
      d = q;
      d.adc = 1'b0;

      // timers
      for (int i = 0; i < 2; i++) begin
         pp = q.p[i];
         pp.sync_l = {q.p[i].sync_l[1:0], ck_pin[2*i]};
         pp.sync_h = {q.p[i].sync_h[1:0], ck_pin[2*i+1]};
         sl = (q.p[i].sync_l[1] == q.p[i].sync_l[2]) ? q.p[i].sync_l[2] : q.p[i].stab_l;
         sh = (q.p[i].sync_h[1] == q.p[i].sync_h[2]) ? q.p[i].sync_h[2] : q.p[i].stab_h;
         rl = sl & ~q.p[i].stab_l;
         rh = sh & ~q.p[i].stab_h;
         fall_l = ~sl & q.p[i].stab_l;
         fall_h = ~sh & q.p[i].stab_h;
         pp.stab_l = sl;
         pp.stab_h = sh;
         comb = q.p[i].conl[B_T32];
         st = ps_step(q.p[i].psl, q.p[i].conl[B_PS_HI:B_PS_LO],
                      timer_adv(q.p[i].conl, sl, rl)); // R6
         pp.psl = st[7:0];
         if (comb) begin
            if (st[8]) begin // R2 R14
               if ({q.p[i].hi, q.p[i].lo} == {q.p[i].prh, q.p[i].prl}) begin
                  pp.hi = CNT_RST; // R16
                  pp.lo = CNT_RST;
                  ev[2*i+1] = 1'b1; // R9
                  if (i == 0) begin
                     d.adc = 1'b1; // R19 R13
                  end
               end else begin
                  cnt32 = {q.p[i].hi, q.p[i].lo} + 32'h0000_0001; // R15
                  pp.hi = cnt32[31:16];
                  pp.lo = cnt32[15:0];
               end
            end
            if (gated(q.p[i].conl) && fall_l) begin
               ev[2*i+1] = 1'b1; // R9
            end
         end else begin
            ch = q.p[i].conh;
            if (st[8]) begin
               if (q.p[i].lo == q.p[i].prl) begin
                  pp.lo = CNT_RST;
                  ev[2*i] = 1'b1;
               end else begin
                  pp.lo = 16'(q.p[i].lo + 16'h0001);
               end
            end
            if (gated(q.p[i].conl) && fall_l) begin
               ev[2*i] = 1'b1;
            end
            st = ps_step(q.p[i].psh, ch[B_PS_HI:B_PS_LO], timer_adv(ch, sh, rh));
            pp.psh = st[7:0];
            if (st[8]) begin
               if (q.p[i].hi == q.p[i].prh) begin
                  pp.hi = CNT_RST;
                  ev[2*i+1] = 1'b1;
               end else begin
                  pp.hi = 16'(q.p[i].hi + 16'h0001);
               end
            end
            if (gated(ch) && fall_h) begin
               ev[2*i+1] = 1'b1;
            end
         end
         d.p[i] = pp;
      end
      // register writes
      if (wr_go) begin
         for (int i = 0; i < 2; i++) begin
            if (wa == reg_addr(IDX_LO_CNT, i[0])) begin
               hit = 1'b1;
               d.p[i].lo = wmerge(q.p[i].lo, q.wdata, q.wstrb);
               if (q.p[i].conl[B_T32]) begin
                  d.p[i].hi = q.p[i].hold; // R17 R11
               end
               if (q.p[i].conl[B_TON]) begin
                  d.p[i].psl = PS_RST; // R3 R6
               end
            end
            if (wa == reg_addr(IDX_HOLD, i[0])) begin
               hit = 1'b1;
               d.p[i].hold = wmerge(q.p[i].hold, q.wdata, q.wstrb);
            end
            if (wa == reg_addr(IDX_HI_CNT, i[0])) begin
               hit = 1'b1;
               d.p[i].hi = wmerge(q.p[i].hi, q.wdata, q.wstrb);
               d.p[i].psh = PS_RST; // R3
            end
            if (wa == reg_addr(IDX_LO_PER, i[0])) begin
               hit = 1'b1;
               d.p[i].prl = wmerge(q.p[i].prl, q.wdata, q.wstrb);
            end
            if (wa == reg_addr(IDX_HI_PER, i[0])) begin
               hit = 1'b1;
               d.p[i].prh = wmerge(q.p[i].prh, q.wdata, q.wstrb);
            end
            if (wa == reg_addr(IDX_LO_CON, i[0])) begin
               hit = 1'b1;
               w16 = wmerge(q.p[i].conl, q.wdata, q.wstrb) & CON_LO_MASK; // R12
               d.p[i].conl = w16; // R7
               if (q.p[i].conl[B_TON] && !w16[B_TON]) begin
                  d.p[i].psl = PS_RST; // R4
               end
            end
            if (wa == reg_addr(IDX_HI_CON, i[0])) begin
               hit = 1'b1;
               w16 = wmerge(q.p[i].conh, q.wdata, q.wstrb) & CON_HI_MASK; // R12
               d.p[i].conh = w16; // R7
               if (q.p[i].conh[B_TON] && !w16[B_TON]) begin
                  d.p[i].psh = PS_RST; // R4
               end
            end
         end
         if (wa == reg_addr(IDX_IRQ_FLAG, 1'b0)) begin
            hit = 1'b1;
            w16 = wmerge(16'(q.flags) << IRQ_FLAG_LSB, q.wdata, q.wstrb);
            d.flags = w16[IRQ_FLAG_LSB +: 4]; // R10
         end
         if (wa == reg_addr(IDX_IRQ_EN, 1'b0)) begin
            hit = 1'b1;
            w16 = wmerge(16'(q.ens) << IRQ_FLAG_LSB, q.wdata, q.wstrb);
            d.ens = w16[IRQ_FLAG_LSB +: 4];
         end
         d.bvalid = 1'b1;
         d.bresp = hit ? RESP_OKAY : RESP_SLVERR;
         d.aw_have = 1'b0;
         d.w_have = 1'b0;
      end
      if (s_axi_awvalid && q.awready) begin
         d.aw_have = 1'b1;
         d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
         d.w_have = 1'b1;
         d.wdata = s_axi_wdata[15:0];
         d.wstrb = s_axi_wstrb[1:0];
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      // register reads
      if (s_axi_arvalid && q.arready) begin
         hit = 1'b0;
         for (int i = 0; i < 2; i++) begin
            if (ra == reg_addr(IDX_LO_CNT, i[0])) begin
               hit = 1'b1;
               rd = q.p[i].lo;
               if (q.p[i].conl[B_T32]) begin
                  d.p[i].hold = q.p[i].hi; // R17 R11
               end
            end
            if (ra == reg_addr(IDX_HOLD, i[0])) begin
               hit = 1'b1;
               rd = q.p[i].hold;
            end
            if (ra == reg_addr(IDX_HI_CNT, i[0])) begin
               hit = 1'b1;
               rd = q.p[i].hi;
            end
            if (ra == reg_addr(IDX_LO_PER, i[0])) begin
               hit = 1'b1;
               rd = q.p[i].prl;
            end
            if (ra == reg_addr(IDX_HI_PER, i[0])) begin
               hit = 1'b1;
               rd = q.p[i].prh;
            end
            if (ra == reg_addr(IDX_LO_CON, i[0])) begin
               hit = 1'b1;
               rd = q.p[i].conl;
            end
            if (ra == reg_addr(IDX_HI_CON, i[0])) begin
               hit = 1'b1;
               rd = q.p[i].conh;
            end
         end
         if (ra == reg_addr(IDX_IRQ_FLAG, 1'b0)) begin
            hit = 1'b1;
            rd = 16'(q.flags) << IRQ_FLAG_LSB;
         end
         if (ra == reg_addr(IDX_IRQ_EN, 1'b0)) begin
            hit = 1'b1;
            rd = 16'(q.ens) << IRQ_FLAG_LSB;
         end
         d.rvalid = 1'b1;
         d.rdata = {16'h0000, rd};
         d.rresp = hit ? RESP_OKAY : RESP_SLVERR;
      end else if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      // hardware set beats software clear
      d.flags = d.flags | ev; // R20
      d.irq = d.flags & d.ens; // R9
      d.awready = ~d.aw_have & ~d.bvalid;
      d.wready = ~d.w_have & ~d.bvalid;
      d.arready = ~d.rvalid;
   end
   // ==========================================================
   // state register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0; // R5
         for (int i = 0; i < 2; i++) begin
            q.p[i].prl <= PER_RST;
            q.p[i].prh <= PER_RST;
            q.p[i].conl <= CON_RST; // R12
            q.p[i].conh <= CON_RST;
            q.p[i].psl <= PS_RST; // R5
            q.p[i].psh <= PS_RST;
         end
         q.awready <= 1'b1;
         q.wready <= 1'b1;
         q.arready <= 1'b1;
      end else begin
         q <= d;
      end
   end
   // ==========================================================
   // outputs
   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign irq_req = q.irq;
   assign adc_trigger = q.adc;
   assign cap_count_lo = q.p[0].lo; // R13
   assign cap_count_hi = q.p[0].hi;
endmodule
`default_nettype wire

// File: test/dtp_timer_pair_assertions.sv
// bus and event checks of the dual timer pair
`timescale 1ns/100ps
`default_nettype none
module dtp_timer_pair_assertions (
   // clock and reset
   input wire logic        clk,
   input wire logic        resetn,
   // register bus
   input wire logic [11:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // power state, pins, events
   input wire logic        cpu_sleep,
   input wire logic        cpu_idle,
   input wire logic [3:0]  ck_pin,
   input wire logic [3:0]  irq_req,
   input wire logic        adc_trigger,
   input wire logic [15:0] cap_count_lo,
   input wire logic [15:0] cap_count_hi
);
   import dtp_pkg::*;
   // ==========================================================
   // sequences
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence aw_hs_s;
      s_axi_awvalid && s_axi_awready;
   endsequence
   sequence ar_hs_s;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence sleep3_s;
      cpu_sleep [*3];
   endsequence
   // ==========================================================
   // properties
   wr_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid) else $error("write response late");
   rd_latency_a: assert property (ar_hs_s |=> s_axi_rvalid) else $error("read data late");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
   aw_block_a: assert property (aw_hs_s |=> !s_axi_awready [*2]) else $error("write taken early");
   rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("read upper half not zero");
   unmapped_rd_a: assert property (ar_hs_s ##0 s_axi_araddr >= 12'hC00
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000) else $error("unmapped read");
   trig_pulse_a: assert property (adc_trigger |=> !adc_trigger) else $error("trigger too long");
   sleep_hold_a: assert property (sleep3_s |-> $stable(cap_count_lo) &&
      $stable(cap_count_hi)) else $error("count moved in sleep");
   cover property (adc_trigger);
endmodule
bind dtp_timer_pair dtp_timer_pair_assertions dtp_timer_pair_assertions_i (
   .clk(clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle), .ck_pin(ck_pin), .irq_req(irq_req),
   .adc_trigger(adc_trigger), .cap_count_lo(cap_count_lo), .cap_count_hi(cap_count_hi));
`default_nettype wire

// File: test/tb_top.sv
// self-checking bench of the dual timer pair
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import dtp_pkg::*;
   logic        clk, resetn, awvalid, wvalid, bready, arvalid, rready, sleep, idle;
   logic        awready, wready, bvalid, arready, rvalid, adc;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v1, v2, v3, r;
   logic [3:0]  wstrb, ck, irq;
   logic [1:0]  bresp, rresp, rs;
   logic [15:0] cnt_lo, cnt_hi;
   int          error_cnt, n_checks, cyc, c1, c2, c3;
   logic [11:0] ridx [8] = '{IDX_LO_CNT, IDX_HOLD, IDX_HI_CNT, IDX_LO_PER, IDX_HI_PER,
                              IDX_LO_CON, IDX_HI_CON, IDX_LO_CON + IDX_PAIR_STRIDE};
   logic [31:0] rexp [8] = '{0, 0, 0, 32'hFFFF, 32'hFFFF, 0, 0, 0};

   dtp_timer_pair dtp_timer_pair_i (
      .clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .cpu_sleep(sleep), .cpu_idle(idle), .ck_pin(ck), .irq_req(irq), .adc_trigger(adc),
      .cap_count_lo(cnt_lo), .cap_count_hi(cnt_hi));

   // ==========================================================
   // clock, timeout, checks
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         error_cnt++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic near(input logic [31:0] got, input int exp, input int tol);
      int d;
      d = int'(got) - exp;
      n_checks++;
      if ($isunknown(got) || d > tol || d < -tol) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic int div_of(input int p);
      return (p == 3) ? 256 : (1 << (3 * p));
   endfunction

   // ==========================================================
   // bus tasks
   task automatic wr(input logic [11:0] idx, input logic [15:0] d, output logic [1:0] resp);
      bit ta;
      bit tw;
      ta = 0;
      tw = 0;
      @(posedge clk);
      awaddr <= {idx[9:0], 2'b00};
      wdata <= {16'h0000, d};
      awvalid <= 1;
      wvalid <= 1;
      do begin
         @(posedge clk);
         if (!ta && awready) begin
            ta = 1;
            awvalid <= 0;
         end
         if (!tw && wready) begin
            tw = 1;
            wvalid <= 0;
         end
      end while (!(ta && tw));
      do @(posedge clk); while (!bvalid);
      bready <= 1;
      @(posedge clk);
      resp = bresp;
      bready <= 0;
   endtask
   task automatic rd(input logic [11:0] idx, output logic [31:0] d, output int c);
      @(posedge clk);
      araddr <= {idx[9:0], 2'b00};
      arvalid <= 1;
      do @(posedge clk); while (!arready);
      arvalid <= 0;
      do @(posedge clk); while (!rvalid);
      rready <= 1;
      @(posedge clk);
      d = rdata;
      rs = rresp;
      c = cyc;
      rready <= 0;
   endtask
   task automatic wait_adc(output int c);
      do @(posedge clk); while (!adc);
      c = cyc;
   endtask

   // ==========================================================
   // scenarios
   initial begin
      {resetn, awvalid, wvalid, bready, arvalid, rready, sleep, idle, ck} = '0;
      {awaddr, araddr, wdata, error_cnt, n_checks} = '0;
      wstrb = 4'hF;
      void'($urandom(97));
      repeat (10) @(posedge clk);
      resetn <= 1;
      foreach (ridx[i]) begin
         rd(ridx[i], v1, c1);
         chk(v1, rexp[i]);
      end
      wr(IDX_LO_CON, 16'hFFFF, rs);
      rd(IDX_LO_CON, v1, c1);
      chk(v1, 32'h0000A07A);
      wr(IDX_LO_CON, 16'h0000, rs);
      wr(IDX_HI_CON, 16'hFFFF, rs);
      rd(IDX_HI_CON, v1, c1);
      chk(v1, 32'h0000A072);
      wr(IDX_HI_CON, 16'h0000, rs);
      repeat (3) begin
         r = $urandom;
         wr(IDX_LO_CNT, r[15:0], rs);
         wr(IDX_LO_CON, 16'($urandom) & 16'h207A, rs);
         rd(IDX_LO_CNT, v1, c1);
         chk(v1, {16'h0000, r[15:0]});
      end
      wr(IDX_LO_CON, 16'h0000, rs);
      rd(12'h300, v1, c1);
      chk(rs, RESP_SLVERR);
      wr(12'h300, 16'h1234, rs);
      chk(rs, RESP_SLVERR);
      for (int p = 0; p < 4; p++) begin
         wr(IDX_LO_CNT, 16'h0000, rs);
         wr(IDX_LO_CON, 16'h8000 | (16'(p) << 4), rs);
         rd(IDX_LO_CNT, v1, c1);
         repeat (6 * div_of(p)) @(posedge clk);
         rd(IDX_LO_CNT, v2, c2);
         near(v2 - v1, (c2 - c1) / div_of(p), 1);
         wr(IDX_LO_CON, 16'h0000, rs);
      end
      wr(IDX_LO_CON, 16'h8030, rs);
      repeat (200) @(posedge clk);
      wr(IDX_LO_CNT, 16'h0000, rs);
      repeat (200) @(posedge clk);
      rd(IDX_LO_CNT, v1, c1);
      chk(v1, 32'h0);
      wr(IDX_LO_CON, 16'hA000, rs);
      sleep <= 1;
      rd(IDX_LO_CNT, v1, c1);
      repeat (20) @(posedge clk);
      rd(IDX_LO_CNT, v2, c2);
      chk(v2, v1);
      sleep <= 0;
      repeat (5) @(posedge clk);
      rd(IDX_LO_CNT, v3, c3);
      near(v3 - v2, c3 - c2, 3);
      idle <= 1;
      rd(IDX_LO_CNT, v1, c1);
      repeat (9) @(posedge clk);
      rd(IDX_LO_CNT, v2, c2);
      chk(v2, v1);
      idle <= 0;
      wr(IDX_LO_CON, 16'h0008, rs);
      wr(IDX_HOLD, 16'hABCD, rs);
      wr(IDX_LO_CNT, 16'h0000, rs);
      rd(IDX_HI_CNT, v1, c1);
      chk(v1, 32'h0000ABCD);
      wr(IDX_HOLD, 16'h0000, rs);
      wr(IDX_LO_CNT, 16'h0000, rs);
      wr(IDX_LO_PER, 16'h0040, rs);
      wr(IDX_HI_PER, 16'h0000, rs);
      wr(IDX_HI_CON, 16'h8030, rs);
      wr(IDX_LO_CON, 16'h8008, rs);
      wait_adc(c1);
      wait_adc(c2);
      chk(c2 - c1, 32'd65);
      chk(irq[1], 1'b0);
      rd(IDX_IRQ_FLAG, v1, c1);
      chk(v1 & 32'h80, 32'h80);
      wr(IDX_IRQ_EN, 16'h0080, rs);
      repeat (2) @(posedge clk);
      chk(irq[1], 1'b1);
      wr(IDX_LO_CON, 16'h0008, rs);
      wr(IDX_IRQ_FLAG, 16'h0000, rs);
      rd(IDX_IRQ_FLAG, v1, c1);
      chk(v1, 32'h0);
      chk(irq[1], 1'b0);
      wr(IDX_HI_CNT, 16'h1357, rs);
      rd(IDX_LO_CNT, v1, c1);
      rd(IDX_HOLD, v2, c2);
      chk(v2, 32'h00001357);
      wr(IDX_HI_CON, 16'h0000, rs);
      wr(IDX_LO_CNT, 16'h0000, rs);
      wr(IDX_LO_CON, 16'h8040, rs);
      repeat (10) @(posedge clk);
      rd(IDX_LO_CNT, v1, c1);
      chk(v1, 32'h0);
      ck[0] <= 1;
      repeat (40) @(posedge clk);
      ck[0] <= 0;
      repeat (10) @(posedge clk);
      rd(IDX_LO_CNT, v2, c2);
      near(v2, 40, 4);
      repeat (20) @(posedge clk);
      rd(IDX_LO_CNT, v3, c3);
      chk(v3, v2);
      rd(IDX_IRQ_FLAG, v1, c1);
      chk(v1 & 32'h40, 32'h40);
      wr(IDX_LO_CON, 16'h0000, rs);
      conclude();
   end
endmodule
`default_nettype wire
